// file: dma_chan_cfg.svh
// Register offsets, field positions, masks and reset values of the channel block.
`ifndef DMA_CHAN_CFG_SVH
`define DMA_CHAN_CFG_SVH

`define NUM_CHAN          8
`define CHAN_AREA         4'h0
`define SHARED_AREA       4'h1

`define REG_CONTROL       3'h0
`define REG_REQUEST       3'h1
`define REG_PRIMARY       3'h2
`define REG_SECONDARY     3'h3
`define REG_PERIPH_ADDR   3'h4
`define REG_COUNT         3'h5

`define REG_COLLISION     3'h0
`define REG_CHAN_STATUS   3'h1

`define CTL_ON_BIT        15
`define CTL_BYTE_BIT      14
`define CTL_DIR_BIT       13
`define CTL_HALF_BIT      12
`define CTL_NULL_BIT      11
`define CTL_ADDRESSING_SELECT_HI      5
`define CTL_ADDRESSING_SELECT_LO      4
`define CTL_MODE_HI       1
`define CTL_MODE_LO       0
`define CTL_MASK          16'hf833
`define CTL_RESET         16'h0000

`define REQ_FORCE_BIT     15
`define REQ_NUM_HI        6
`define REQ_NUM_LO        0
`define REQ_NUM_RESET     7'h00

`define START_RESET       16'h0000
`define PAD_RESET         16'h0000
`define COUNT_RESET       10'h000

`define LAST_CHAN_RESET   4'hf
`define STEP_BYTE         16'h0001
`define STEP_WORD         16'h0002

`endif

// file: dma_chan_pkg.sv
// Types shared by the channel block: addressing, block modes and channel states.
package dma_chan_pkg;

    typedef enum logic [1:0] {
        AM_POSTINC = 2'h0,
        AM_NOINC   = 2'h1,
        AM_PERIPH  = 2'h2,
        AM_RSVD    = 2'h3
    } addressing_e;

    typedef enum logic [1:0] {
        OM_CONT       = 2'h0,
        OM_ONESHOT    = 2'h1,
        OM_CONT_PP    = 2'h2,
        OM_ONESHOT_PP = 2'h3
    } op_mode_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_RUN  = 3'h2,
        ST_HALT = 3'h4
    } chan_state_e;

endpackage

// file: dma_chan_seq.sv
// Per-channel block sequencer: address walk, block count, ping-pong, stop.
`include "dma_chan_cfg.svh"
module dma_chan_seq (
    // Clock and reset
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // Configuration
    input  wire logic                      on,
    input  wire logic                      byte_mode,
    input  wire logic                      half,
    input  wire dma_chan_pkg::addressing_e addressing_select,
    input  wire dma_chan_pkg::op_mode_e    mode,
    input  wire logic [15:0]               start_a,
    input  wire logic [15:0]               start_b,
    input  wire logic [9:0]                count,
    // Requests
    input  wire logic                      trig,
    input  wire logic                      force_req,
    input  wire logic                      grant,
    // Status
    output logic                           req,
    output logic [15:0]                    ram_addr,
    output logic                           pingpong,
    output logic                           irq,
    output logic                           stop,
    output logic                           force_done
);
    import dma_chan_pkg::*;

    chan_state_e  state;
    logic         trig_pend;
    logic [9:0]   done;
    logic [10:0]  moved;
    logic [10:0]  half_pt;
    logic         last;
    logic         one_shot_end;
    logic         pp_mode;

    assign moved        = {1'b0, done} + 11'h001;
    assign half_pt      = ({1'b0, count} + 11'h001) >> 1;
    assign last         = (done == count);
    assign pp_mode      = (mode == OM_CONT_PP) || (mode == OM_ONESHOT_PP);
    assign one_shot_end = (mode == OM_ONESHOT) ||
                          (mode == OM_ONESHOT_PP && pingpong);

    assign req        = on && state == ST_RUN && (trig_pend || force_req);
    assign stop       = grant && last && one_shot_end;
    assign force_done = grant && force_req;
    // A one-transfer block has no half point, so it interrupts at its end.
    assign irq = grant && (half ? (moved == half_pt || (last && half_pt == 11'h000))
                                : last);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
        end else if (!on) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: state <= ST_RUN;
                ST_RUN:  if (stop) begin
                    state <= ST_HALT;
                end
                ST_HALT: state <= ST_HALT;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // A forced transfer is served first, so a pending trigger is kept for later.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_pend <= 1'b0;
        end else if (state != ST_RUN) begin
            trig_pend <= 1'b0;
        end else begin
            trig_pend <= trig || (trig_pend && !(grant && !force_req));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ram_addr <= `START_RESET;
            pingpong <= 1'b0;
            done     <= 10'h000;
        end else if (state == ST_IDLE) begin
            ram_addr <= start_a;
            pingpong <= 1'b0;
            done     <= 10'h000;
        end else if (grant) begin
            if (last) begin
                done <= 10'h000;
                if (pp_mode) begin
                    pingpong <= ~pingpong;
                    ram_addr <= pingpong ? start_a : start_b;
                end else begin
                    ram_addr <= start_a;
                end
            end else begin
                done <= done + 10'h001;
                if (addressing_select == AM_POSTINC) begin
                    ram_addr <= ram_addr +
                                (byte_mode ? `STEP_BYTE : `STEP_WORD);
                end
            end
        end
    end

endmodule

// file: dma_channel_config.sv
// Eight-channel setup registers, APB slave, arbitration and transfer issue.
`include "dma_chan_cfg.svh"
// Operation
// - Each channel has a ten-bit count; other channel registers are sixteen bits.
// - Two status registers are shared by all channels.
// - Control bit 15 turns the channel on; it resets to zero.
// - Control bit 14 set moves bytes, clear moves words.
// - Control bit 13 set reads RAM, writes peripheral; clear is the reverse.
// - Control bit 12 set raises the block interrupt at half block.
// - Control bit 11 adds null peripheral writes; direction must stay clear.
// - Bits 5-4 pick post-increment, no increment, peripheral indirect, reserved.
// - Bits 1-0 pick continuous, one-shot, continuous ping-pong, one-shot ping-pong.
// - One-shot ping-pong runs one primary and one secondary block, then stops.
// - Request bit 15 forces one transfer; otherwise the selected request starts.
// - Software cannot clear the force bit; hardware clears it when done.
// - A seven-bit number selects one of 128 request lines as trigger.
// - Primary start register holds a sixteen-bit RAM start offset.
// - Secondary start register holds the alternate ping-pong buffer base.
// - A block is one transfer more than the programmed count.
// - Continuous modes reload the buffer start after each block.
// - Each channel raises its own interrupt at block end or half.
// - Ping-pong status reads one while the secondary buffer is active.
module dma_channel_config (
    // Clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // APB slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    // Peripheral request lines and collision events
    input  wire logic [127:0]  irq_lines,
    input  wire logic [7:0]    periph_collision,
    input  wire logic [7:0]    ram_collision,
    // Transfer issue
    output logic               xfer_valid,
    output logic      [2:0]    xfer_chan,
    output logic      [15:0]   xfer_ram_addr,
    output logic      [15:0]   xfer_periph_addr,
    output logic               xfer_dir,
    output logic               xfer_byte,
    output logic               xfer_null,
    output logic               xfer_periph_indirect,
    // Per-channel block interrupt requests
    output logic      [7:0]    chan_irq
);
    import dma_chan_pkg::*;

    logic [15:0]       ctl [`NUM_CHAN];
    logic [7:0][6:0]   req_num;
    logic [7:0]        force_bit;
    logic [15:0]       primary_start [`NUM_CHAN];
    logic [15:0]       stb [`NUM_CHAN];
    logic [15:0]       pad [`NUM_CHAN];
    logic [9:0]        cnt [`NUM_CHAN];
    logic [15:0]       coll;
    logic [3:0]        last_chan;

    logic [7:0]        trig;
    logic [7:0]        req;
    logic [7:0]        gnt;
    logic [2:0]        gidx;
    logic [15:0]       ram_addr_v [`NUM_CHAN];
    logic [7:0]        pp;
    logic [7:0]        irq_v;
    logic [7:0]        stop_v;
    logic [7:0]        force_done_v;

    logic              access;
    logic              wr;
    logic [2:0]        chan;
    logic [2:0]        rsel;
    logic [31:0]       rdata;

    function automatic logic addr_ok(input logic [11:0] a);
        logic chan_hit;
        logic shared_hit;
        chan_hit   = a[11:8] == `CHAN_AREA && a[4:2] <= `REG_COUNT;
        shared_hit = a[11:8] == `SHARED_AREA && a[7:5] == 3'h0 &&
                     a[4:2] <= `REG_CHAN_STATUS;
        return a[1:0] == 2'h0 && (chan_hit || shared_hit);
    endfunction

    function automatic logic chan_reg(input logic [11:0] a,
                                      input logic [2:0]  r);
        return addr_ok(a) && a[11:8] == `CHAN_AREA && a[4:2] == r;
    endfunction

    assign access = psel && penable;
    assign wr     = access && pready && pwrite && addr_ok(paddr);
    assign chan   = paddr[7:5];
    assign rsel   = paddr[4:2];

    // One wait state: the answer comes on the second access-phase cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= access && !pready;
            if (access && !pready) begin
                prdata  <= pwrite ? 32'h0000_0000 : rdata;
                pslverr <= !addr_ok(paddr);
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    always_comb begin
        rdata = 32'h0000_0000;
        if (addr_ok(paddr) && paddr[11:8] == `CHAN_AREA) begin
            case (rsel)
                `REG_CONTROL:     rdata = {16'h0000, ctl[chan]};
                `REG_REQUEST:     rdata = {16'h0000, force_bit[chan],
                                           8'h00, req_num[chan]};
                `REG_PRIMARY:     rdata = {16'h0000, primary_start[chan]};
                `REG_SECONDARY:   rdata = {16'h0000, stb[chan]};
                `REG_PERIPH_ADDR: rdata = {16'h0000, pad[chan]};
                `REG_COUNT:       rdata = {22'h00_0000, cnt[chan]};
                default:          rdata = 32'h0000_0000;
            endcase
        end else if (addr_ok(paddr)) begin
            case (rsel)
                `REG_COLLISION:   rdata = {16'h0000, coll};
                `REG_CHAN_STATUS: rdata = {20'h0_0000, last_chan, pp};
                default:          rdata = 32'h0000_0000;
            endcase
        end
    end

    genvar g;
    generate
        for (g = 0; g < `NUM_CHAN; g++) begin : g_chan
            logic hit;
            assign hit = wr && chan == 3'(g);

            // A software write in the same cycle as a one-shot stop wins.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ctl[g] <= `CTL_RESET;
                end else if (hit && chan_reg(paddr, `REG_CONTROL)) begin
                    ctl[g] <= pwdata[15:0] & `CTL_MASK;
                end else if (stop_v[g]) begin
                    ctl[g][`CTL_ON_BIT] <= 1'b0;
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    req_num[g]   <= `REQ_NUM_RESET;
                    force_bit[g] <= 1'b0;
                end else begin
                    if (hit && chan_reg(paddr, `REG_REQUEST)) begin
                        req_num[g] <= pwdata[`REQ_NUM_HI:`REQ_NUM_LO];
                    end
                    force_bit[g] <= (hit && chan_reg(paddr, `REG_REQUEST) &&
                                     pwdata[`REQ_FORCE_BIT]) ||
                                    (force_bit[g] && !force_done_v[g]);
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    primary_start[g] <= `START_RESET;
                    stb[g] <= `START_RESET;
                    pad[g] <= `PAD_RESET;
                    cnt[g] <= `COUNT_RESET;
                end else if (hit) begin
                    if (chan_reg(paddr, `REG_PRIMARY)) begin
                        primary_start[g] <= pwdata[15:0];
                    end
                    if (chan_reg(paddr, `REG_SECONDARY)) begin
                        stb[g] <= pwdata[15:0];
                    end
                    if (chan_reg(paddr, `REG_PERIPH_ADDR)) begin
                        pad[g] <= pwdata[15:0];
                    end
                    if (chan_reg(paddr, `REG_COUNT)) begin
                        cnt[g] <= pwdata[9:0];
                    end
                end
            end

            dma_chan_seq u_seq (
                .pclk       (pclk),
                .presetn    (presetn),
                .on         (ctl[g][`CTL_ON_BIT]),
                .byte_mode  (ctl[g][`CTL_BYTE_BIT]),
                .half       (ctl[g][`CTL_HALF_BIT]),
                .addressing_select      (addressing_e'(ctl[g][`CTL_ADDRESSING_SELECT_HI:`CTL_ADDRESSING_SELECT_LO])),
                .mode       (op_mode_e'(ctl[g][`CTL_MODE_HI:`CTL_MODE_LO])),
                .start_a    (primary_start[g]),
                .start_b    (stb[g]),
                .count      (cnt[g]),
                .trig       (trig[g]),
                .force_req  (force_bit[g]),
                .grant      (gnt[g]),
                .req        (req[g]),
                .ram_addr   (ram_addr_v[g]),
                .pingpong   (pp[g]),
                .irq        (irq_v[g]),
                .stop       (stop_v[g]),
                .force_done (force_done_v[g])
            );
        end
    endgenerate

    dma_req_select #(
        .CH    (`NUM_CHAN),
        .LINES (128)
    ) u_req_select (
        .pclk      (pclk),
        .presetn   (presetn),
        .irq_lines (irq_lines),
        .sel       (req_num),
        .trig      (trig)
    );

    // Fixed priority: the lowest-numbered requesting channel moves first.
    always_comb begin
        gnt  = 8'h00;
        gidx = 3'h0;
        for (int i = `NUM_CHAN - 1; i >= 0; i--) begin
            if (req[i]) begin
                gnt  = 8'h01 << i;
                gidx = 3'(i);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xfer_valid           <= 1'b0;
            xfer_chan            <= 3'h0;
            xfer_ram_addr        <= 16'h0000;
            xfer_periph_addr     <= 16'h0000;
            xfer_dir             <= 1'b0;
            xfer_byte            <= 1'b0;
            xfer_null            <= 1'b0;
            xfer_periph_indirect <= 1'b0;
            chan_irq             <= 8'h00;
        end else begin
            xfer_valid <= |gnt;
            chan_irq   <= irq_v;
            if (|gnt) begin
                xfer_chan        <= gidx;
                xfer_ram_addr    <= ram_addr_v[gidx];
                xfer_periph_addr <= pad[gidx];
                xfer_dir         <= ctl[gidx][`CTL_DIR_BIT];
                xfer_byte        <= ctl[gidx][`CTL_BYTE_BIT];
                // Null writes are suppressed when the direction is misprogrammed.
                xfer_null        <= ctl[gidx][`CTL_NULL_BIT] &&
                                    !ctl[gidx][`CTL_DIR_BIT];
                xfer_periph_indirect <=
                    ctl[gidx][`CTL_ADDRESSING_SELECT_HI:`CTL_ADDRESSING_SELECT_LO] == AM_PERIPH;
            end
        end
    end

    // Collision flags: an event in the clearing cycle keeps its flag set.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coll <= 16'h0000;
        end else if (wr && paddr[11:8] == `SHARED_AREA &&
                     rsel == `REG_COLLISION) begin
            coll <= {periph_collision, ram_collision} | (coll & pwdata[15:0]);
        end else begin
            coll <= {periph_collision, ram_collision} | coll;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_chan <= `LAST_CHAN_RESET;
        end else if (|gnt) begin
            last_chan <= {1'b0, gidx};
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_count_width;
        access && pready && !pwrite && chan_reg(paddr, `REG_COUNT)
            |-> prdata[31:10] == 22'h00_0000;
    endproperty
    a_count_width: assert property (p_count_width)
        else $error("count register reads bits above nine");

    property p_last_chan;
        xfer_valid |-> last_chan == {1'b0, xfer_chan};
    endproperty
    a_last_chan: assert property (p_last_chan)
        else $error("last channel status does not match transfer");

    property p_on_needed;
        xfer_valid |-> $past(ctl[gidx][`CTL_ON_BIT]);
    endproperty
    a_on_needed: assert property (p_on_needed)
        else $error("transfer issued by a disabled channel");

    property p_byte;
        xfer_valid |-> xfer_byte == $past(ctl[gidx][`CTL_BYTE_BIT]);
    endproperty
    a_byte: assert property (p_byte)
        else $error("transfer size does not follow control");

    property p_dir;
        xfer_valid |-> xfer_dir == $past(ctl[gidx][`CTL_DIR_BIT]);
    endproperty
    a_dir: assert property (p_dir)
        else $error("transfer direction does not follow control");

    property p_null;
        xfer_valid && xfer_null |-> !xfer_dir;
    endproperty
    a_null: assert property (p_null)
        else $error("null write outside a peripheral-to-RAM transfer");

    property p_force_kept;
        wr && chan_reg(paddr, `REG_REQUEST) && chan == 3'h1 &&
            force_bit[1] && !force_done_v[1] |=> force_bit[1];
    endproperty
    a_force_kept: assert property (p_force_kept)
        else $error("software cleared the force bit");

    property p_force_clear;
        force_done_v[0] && !(wr && chan_reg(paddr, `REG_REQUEST) &&
            chan == 3'h0 && pwdata[`REQ_FORCE_BIT]) |=> !force_bit[0];
    endproperty
    a_force_clear: assert property (p_force_clear)
        else $error("force bit not cleared after forced transfer");

    property p_irq_pairs;
        |chan_irq |-> xfer_valid && chan_irq == (8'h01 << xfer_chan);
    endproperty
    a_irq_pairs: assert property (p_irq_pairs)
        else $error("channel interrupt without its own transfer");

    property p_pp_read;
        access && pready && !pwrite && paddr == 12'h104
            |-> prdata[7:0] == $past(pp);
    endproperty
    a_pp_read: assert property (p_pp_read)
        else $error("ping-pong status read wrong");

    property p_one_wait;
        access && !pready |=> pready ##1 !pready;
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("APB answer not after one wait state");

    c_byte_xfer:  cover property (xfer_valid && xfer_byte);
    c_chan_irq:   cover property (|chan_irq);
    c_force_done: cover property (|force_done_v);
    c_pp_toggle:  cover property ($rose(pp[0]));

endmodule

// file: dma_channel_config_tb.sv
// Testbench for the channel setup block driven over APB.
module dma_channel_config_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic         pclk, presetn, psel, penable, pwrite;
    logic         pready, pslverr, xv, go, err;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, rd;
    logic [6:0]   rnum;
    logic [15:0]  xa, last, xp;
    logic [7:0]   irq, nx, ni, col;
    logic [2:0]   xc;
    wire  [3:0]   xf;
    logic [127:0] lines;
    int           num_errors = 0;
    int           n_tests = 0;
    int           cyc = 0;

    dma_channel_config dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq_lines(lines), .periph_collision(8'h00), .ram_collision(col),
        .xfer_valid(xv), .xfer_chan(xc), .xfer_ram_addr(xa),
        .xfer_periph_addr(xp), .xfer_dir(xf[3]), .xfer_byte(xf[2]),
        .xfer_null(xf[1]), .xfer_periph_indirect(xf[0]), .chan_irq(irq));
    dma_far_model far (.pclk(pclk), .presetn(presetn), .req_num(rnum),
        .req_go(go), .xfer_valid(xv), .xfer_ram_addr(xa), .chan_irq(irq),
        .irq_lines(lines), .last_addr(last), .n_xfer(nx), .n_irq(ni));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic report_and_stop;
        if (num_errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // The whole sequence needs well under a thousand cycles.
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            report_and_stop;
        end
    end

    task automatic chk(input string s, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("FAIL %s exp %h got %h", s, e, g);
            num_errors++;
        end
    endtask

    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] e,
                        input logic [31:0] m);
        apb(a, 1'b0, 32'h0);
        chk($sformatf("reg %h", a), e, rd & m);
    endtask

    // Fires one request edge, then compares address and counters.
    task automatic fire(input logic [6:0] n, input logic [31:0] e);
        rnum <= n;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        repeat (8) @(posedge pclk);
        chk("xfer", e, {last, nx, ni});
    endtask

    initial begin
        logic [11:0] ta[5] = '{12'h040, 12'h054, 12'h048, 12'h04c, 12'h044};
        logic [31:0] tw[5] = '{32'hffff5fff, 32'hffff, 32'ha5c3, 32'h5a3c,
                               32'h007f};
        logic [31:0] te[5] = '{32'h5833, 32'h03ff, 32'ha5c3, 32'h5a3c,
                               32'h007f};
        {col, psel, penable, pwrite, go, presetn} = 13'h0000;
        paddr = 12'h000;
        pwdata = 32'h0;
        rnum = 7'h00;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(12'h000, 32'h0, 32'hffffffff);
        rchk(12'h104, 32'h0f00, 32'hffffffff);
        // Channel 2 keeps direction clear while the null write bit is set.
        for (int i = 0; i < 5; i++) begin
            apb(ta[i], 1'b1, tw[i]);
            rchk(ta[i], te[i], 32'hffffffff);
        end
        apb(12'h300, 1'b0, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        apb(12'h014, 1'b1, 32'h1);
        apb(12'h008, 1'b1, 32'h40);
        apb(12'h004, 1'b1, 32'h5);
        apb(12'h000, 1'b1, 32'h9800);
        fire(7'd5, {16'h0040, 8'd1, 8'd1});
        fire(7'd5, {16'h0042, 8'd2, 8'd1});
        fire(7'd5, {16'h0040, 8'd3, 8'd2});
        apb(12'h034, 1'b1, 32'h0);
        apb(12'h028, 1'b1, 32'h10);
        apb(12'h02c, 1'b1, 32'h80);
        apb(12'h030, 1'b1, 32'h1234);
        apb(12'h024, 1'b1, 32'h9);
        apb(12'h020, 1'b1, 32'he023);
        fire(7'd9, {16'h0010, 8'd4, 8'd3});
        rchk(12'h104, 32'h0102, 32'h0f02);
        chk("fields", 32'h001d_1234, {9'h0, xc, xf, xp});
        fire(7'd9, {16'h0080, 8'd5, 8'd4});
        rchk(12'h020, 32'h6023, 32'hffffffff);
        fire(7'd9, {16'h0080, 8'd5, 8'd4});
        apb(12'h004, 1'b1, 32'h8005);
        repeat (8) @(posedge pclk);
        chk("force", {16'h0042, 8'd6}, {last, nx});
        chk("fields", 32'h0002_0000, {9'h0, xc, xf, xp});
        rchk(12'h004, 32'h0005, 32'hffffffff);
        // Channel 1 is off, so its force request stays pending.
        apb(12'h024, 1'b1, 32'h8009);
        apb(12'h024, 1'b1, 32'h0009);
        rchk(12'h024, 32'h8009, 32'hffffffff);
        col <= 8'h04;
        @(posedge pclk);
        col <= 8'h00;
        rchk(12'h100, 32'h0004, 32'hffffffff);
        apb(12'h100, 1'b1, 32'h0);
        rchk(12'h100, 32'h0000, 32'hffffffff);
        report_and_stop;
    end
endmodule

// file: dma_far_model.sv
// Far side model: request line source and transfer recorder.
module dma_far_model (
    // Clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // Request command from the bench
    input  wire logic [6:0]    req_num,
    input  wire logic          req_go,
    // Transfer issue from the block
    input  wire logic          xfer_valid,
    input  wire logic [15:0]   xfer_ram_addr,
    input  wire logic [7:0]    chan_irq,
    // Request lines and records
    output logic      [127:0]  irq_lines,
    output logic      [15:0]   last_addr,
    output logic      [7:0]    n_xfer,
    output logic      [7:0]    n_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    // A line drops after one cycle so each command is a fresh edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_lines <= '0;
            last_addr <= 16'h0000;
            n_xfer <= 8'h00;
            n_irq <= 8'h00;
        end else begin
            irq_lines <= req_go ? (128'h1 << req_num) : '0;
            if (xfer_valid) begin
                last_addr <= xfer_ram_addr;
                n_xfer <= n_xfer + 8'h01;
            end
            if (|chan_irq) n_irq <= n_irq + 8'h01;
        end
    end
endmodule

// file: dma_req_select.sv
// Edge detection and selection of each channel's trigger among the request lines.
module dma_req_select #(
    parameter int CH    = 8,
    parameter int LINES = 128
) (
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // Request lines and per-channel selection
    input  wire logic [LINES-1:0]      irq_lines,
    input  wire logic [CH-1:0][6:0]    sel,
    // Per-channel trigger pulses
    output logic      [CH-1:0]         trig
);
    logic [LINES-1:0] prev;

    // A held request line triggers only once, on its rising edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev <= '0;
        end else begin
            prev <= irq_lines;
        end
    end

    genvar g;
    generate
        for (g = 0; g < CH; g++) begin : g_sel
            assign trig[g] = irq_lines[sel[g]] & ~prev[sel[g]];
        end
    endgenerate

endmodule
